// file: verilog/kds_pkg.sv
// Constants shared by the front-panel keypad and display scanner.
// Assumes one 200 MHz system clock and a host that writes raw segment patterns.
package kds_pkg;
   localparam int CLK_FREQ_MHZ = 200;
   localparam int DIGIT_TIME_NS = 2000;
   localparam int BLANK_TIME_NS = 500;
   localparam int DIGIT_CYCLES = DIGIT_TIME_NS * CLK_FREQ_MHZ / 1000;
   localparam int BLANK_CYCLES = (BLANK_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam logic [11:0] DIGIT_LAST = 12'(DIGIT_CYCLES - 1);
   localparam logic [11:0] BLANK_LAST = 12'(BLANK_CYCLES - 1);
   localparam int NUM_DIGITS = 16;
   localparam int DIGITS_B_USED = 14;
   localparam int LED_GROUP_FIRST = 9;
   localparam int LED_GROUPS = 5;
   localparam int KEY_ROWS = 8;
   localparam logic [3:0] LAST_DIGIT = 4'hf;
   localparam logic [7:0] SEG_RESET = 8'h00;
   localparam logic [2:0] PANEL_SEL_A = 3'h0;
   localparam logic [2:0] PANEL_SEL_B = 3'h1;
   localparam logic [2:0] HOST_INT_PRIORITY = 3'h3;
   localparam logic [2:0] DEBOUNCE_FRAMES = 3'h3;
   localparam logic [63:0] KEY_USED_MASK = 64'h00ff_ffff_ffff_ffff;
   localparam int RDATA_PENDING_BIT = 7;
endpackage : kds_pkg

// file: verilog/kds_disp.sv
// One display controller: segment store, digit scan timer and blanking.
// Assumes an active-low reset already synchronised to clk and one digit write per cycle.
`timescale 1ns/100ps
module kds_disp
   import kds_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [3:0] wr_digit,
   input wire logic [7:0] wr_data,
   output logic [3:0] scan_code_q,
   output logic blank_n_q,
   output logic [7:0] seg_q,
   output logic slot_end
);
   logic [11:0] tmr_q;
   logic [11:0] tmr_d;
   logic [3:0] scan_code_d;
   logic blank_n_d;
   logic [7:0] seg_d;
   logic [7:0] ram_q [NUM_DIGITS];

   // Each digit is stored raw; the host supplies the segment pattern.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_DIGITS; gi++) begin : g_ram
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               ram_q[gi] <= SEG_RESET;
            end else if (wr_en && wr_digit == 4'(gi)) begin
               ram_q[gi] <= wr_data;
            end
         end
      end
   endgenerate

   assign slot_end = (tmr_q == DIGIT_LAST);

   always_comb begin
      tmr_d = tmr_q + 12'h001;
      scan_code_d = scan_code_q;
      if (slot_end) begin
         tmr_d = 12'h000;
         scan_code_d = scan_code_q + 4'h1;
      end
      // Blank the start of every slot so the old digit fades before the new one.
      blank_n_d = (tmr_d > BLANK_LAST);
      seg_d = ram_q[scan_code_d];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr_q <= 12'h000;
         scan_code_q <= 4'h0;
         blank_n_q <= 1'b0;
         seg_q <= SEG_RESET;
      end else begin
         tmr_q <= tmr_d;
         scan_code_q <= scan_code_d;
         blank_n_q <= blank_n_d;
         seg_q <= seg_d;
      end
   end
endmodule : kds_disp

// file: verilog/kds_top.sv
// Front-panel scanner: host decode, two display scanners, digit decoders and key scan.
// Assumes host signals synchronous to CLK_SYS and a one-cycle HOST_STROBE per access.
`timescale 1ns/100ps
module kds_top
   import kds_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic HOST_STROBE,
   input wire logic HOST_WRITE,
   input wire logic [2:0] PANEL_ADDRESS_BITS,
   input wire logic [3:0] HOST_DIGIT,
   input wire logic [7:0] HOST_WDATA,
   input wire logic [7:0] KEY_RETURN_LINES,
   output logic [7:0] HOST_RDATA,
   output logic HOST_RVALID,
   output logic HOST_INT_N,
   output logic [2:0] HOST_INT_LEVEL,
   output logic [3:0] SCAN_CODE_A,
   output logic [3:0] SCAN_CODE_B,
   output logic BLANK_DIGITS_A_N,
   output logic BLANK_DIGITS_B_N,
   output logic [3:0] SEGMENT_BUS_A_LOW,
   output logic [3:0] SEGMENT_BUS_A_HIGH,
   output logic [3:0] SEGMENT_BUS_B_LOW,
   output logic [3:0] SEGMENT_BUS_B_HIGH,
   output logic [15:0] DIGIT_ANODE_A,
   output logic [13:0] DIGIT_ANODE_B,
   output logic [4:0] KEY_LED_ANODE,
   output logic [7:0] KEY_LED_CATHODE,
   output logic [7:0] KEY_SELECT
);
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // Host strobe decode: one select per controller.
   logic sel_a;
   logic sel_b;
   assign sel_a = HOST_STROBE && (PANEL_ADDRESS_BITS == PANEL_SEL_A);
   assign sel_b = HOST_STROBE && (PANEL_ADDRESS_BITS == PANEL_SEL_B);

   logic [7:0] seg_a;
   logic [7:0] seg_b;
   logic slot_end_a;
   logic slot_end_b;

   kds_disp u_disp_a (
      .clk(CLK_SYS),
      .rst_n(rst_n),
      .wr_en(sel_a && HOST_WRITE),
      .wr_digit(HOST_DIGIT),
      .wr_data(HOST_WDATA),
      .scan_code_q(SCAN_CODE_A),
      .blank_n_q(BLANK_DIGITS_A_N),
      .seg_q(seg_a),
      .slot_end(slot_end_a)
   );

   kds_disp u_disp_b (
      .clk(CLK_SYS),
      .rst_n(rst_n),
      .wr_en(sel_b && HOST_WRITE),
      .wr_digit(HOST_DIGIT),
      .wr_data(HOST_WDATA),
      .scan_code_q(SCAN_CODE_B),
      .blank_n_q(BLANK_DIGITS_B_N),
      .seg_q(seg_b),
      .slot_end(slot_end_b)
   );

   assign SEGMENT_BUS_A_LOW = seg_a[3:0];
   assign SEGMENT_BUS_A_HIGH = seg_a[7:4];
   assign SEGMENT_BUS_B_LOW = seg_b[3:0];
   assign SEGMENT_BUS_B_HIGH = seg_b[7:4];

   // Digit decoders and key select, registered so the pins come from flops.
   // They lag the scan code by one cycle, so each digit select is also dropped on the last cycle of a slot; the key select is not.
   // Otherwise the old digit would flash for one cycle with the new digit's segments.
   logic [15:0] anode_a_d;
   logic [13:0] anode_b_d;
   logic [4:0] led_anode_d;
   logic [7:0] led_cathode_d;
   logic [7:0] key_select_d;
   logic [15:0] dec_b;

   always_comb begin
      anode_a_d = 16'h0000;
      if (BLANK_DIGITS_A_N && !slot_end_a) begin
         anode_a_d[SCAN_CODE_A] = 1'b1;
      end
      dec_b = 16'h0000;
      if (BLANK_DIGITS_B_N && !slot_end_b) begin
         dec_b[SCAN_CODE_B] = 1'b1;
      end
      anode_b_d = dec_b[DIGITS_B_USED-1:0];
      led_anode_d = dec_b[LED_GROUP_FIRST +: LED_GROUPS];
      // Separate cathode drive only while a key LED group is lit.
      led_cathode_d = (|led_anode_d) ? seg_b : 8'h00;
      key_select_d = 8'h00;
      key_select_d[SCAN_CODE_B[2:0]] = 1'b1;
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         DIGIT_ANODE_A <= 16'h0000;
         DIGIT_ANODE_B <= 14'h0000;
         KEY_LED_ANODE <= 5'h00;
         KEY_LED_CATHODE <= 8'h00;
         KEY_SELECT <= 8'h00;
      end else begin
         DIGIT_ANODE_A <= anode_a_d;
         DIGIT_ANODE_B <= anode_b_d;
         KEY_LED_ANODE <= led_anode_d;
         KEY_LED_CATHODE <= led_cathode_d;
         KEY_SELECT <= key_select_d;
      end
   end

   // Key scan on the second controller only; the first never samples returns.
   // Returns are sampled at the end of each of the first eight slots of a frame,
   // when the select line has been stable since the second cycle of the slot.
   logic [1:0] hits_q;
   logic [1:0] hits_d;
   logic [5:0] hit_code_q;
   logic [5:0] hit_code_d;
   logic [5:0] stab_code_q;
   logic [5:0] stab_code_d;
   logic [2:0] stab_cnt_q;
   logic [2:0] stab_cnt_d;
   logic reported_q;
   logic reported_d;
   logic [5:0] key_code_q;
   logic [5:0] key_code_d;
   logic pending_q;
   logic pending_d;
   logic new_key;
   logic sample;
   logic frame_end;
   logic [5:0] pos;

   assign sample = slot_end_b && !SCAN_CODE_B[3];
   assign frame_end = slot_end_b && (SCAN_CODE_B == LAST_DIGIT);

   always_comb begin
      hits_d = hits_q;
      hit_code_d = hit_code_q;
      stab_code_d = stab_code_q;
      stab_cnt_d = stab_cnt_q;
      reported_d = reported_q;
      key_code_d = key_code_q;
      new_key = 1'b0;
      pos = 6'h00;
      if (sample) begin
         for (int i = 0; i < KEY_ROWS; i++) begin
            pos = {SCAN_CODE_B[2:0], 3'(i)};
            // Empty crossings are masked so noise there is never a key.
            if (KEY_RETURN_LINES[i] && KEY_USED_MASK[pos]) begin
               if (hits_d != 2'h2) begin
                  hits_d = hits_d + 2'h1;
               end
               hit_code_d = pos;
            end
         end
      end
      if (frame_end) begin
         hits_d = 2'h0;
         hit_code_d = 6'h00;
         if (hits_q == 2'h0) begin
            stab_cnt_d = 3'h0;
            reported_d = 1'b0;
         end else if (hits_q == 2'h1) begin
            if (hit_code_q != stab_code_q) begin
               stab_code_d = hit_code_q;
               stab_cnt_d = 3'h1;
               reported_d = 1'b0;
            end else if (stab_cnt_q != DEBOUNCE_FRAMES) begin
               stab_cnt_d = stab_cnt_q + 3'h1;
            end
            // A key counts once it has been alone and steady for enough frames.
            if (stab_cnt_d == DEBOUNCE_FRAMES && !reported_d) begin
               new_key = 1'b1;
               reported_d = 1'b1;
               key_code_d = stab_code_d;
            end
         end
         // Two or more keys down: hold state, so no key is reported until one remains.
      end
   end

   // The set wins over a read in the same cycle, so no closure is lost.
   always_comb begin
      pending_d = pending_q;
      if (sel_b && !HOST_WRITE) begin
         pending_d = 1'b0;
      end
      if (new_key) begin
         pending_d = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         hits_q <= 2'h0;
         hit_code_q <= 6'h00;
         stab_code_q <= 6'h00;
         stab_cnt_q <= 3'h0;
         reported_q <= 1'b0;
         key_code_q <= 6'h00;
         pending_q <= 1'b0;
      end else begin
         hits_q <= hits_d;
         hit_code_q <= hit_code_d;
         stab_code_q <= stab_code_d;
         stab_cnt_q <= stab_cnt_d;
         reported_q <= reported_d;
         key_code_q <= key_code_d;
         pending_q <= pending_d;
      end
   end

   // Host read answer and interrupt pins.
   logic [7:0] rdata_d;
   logic rvalid_d;
   logic int_n_d;
   logic [2:0] int_level_d;

   always_comb begin
      rdata_d = HOST_RDATA;
      rvalid_d = 1'b0;
      if (HOST_STROBE && !HOST_WRITE) begin
         rvalid_d = 1'b1;
         rdata_d = 8'h00;
         if (sel_b) begin
            rdata_d[5:0] = key_code_q;
            rdata_d[RDATA_PENDING_BIT] = pending_q;
         end
      end
      // The request is active high inside and leaves inverted.
      int_n_d = !pending_d;
      int_level_d = pending_d ? HOST_INT_PRIORITY : 3'h0;
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         HOST_RDATA <= 8'h00;
         HOST_RVALID <= 1'b0;
         HOST_INT_N <= 1'b1;
         HOST_INT_LEVEL <= 3'h0;
      end else begin
         HOST_RDATA <= rdata_d;
         HOST_RVALID <= rvalid_d;
         HOST_INT_N <= int_n_d;
         HOST_INT_LEVEL <= int_level_d;
      end
   end
endmodule : kds_top

// file: verif/kds_chk.sv
// Port assertions for the panel scanner.
// Assumes it is bound to kds_top and sees only its ports.
`timescale 1ns/100ps
module kds_chk
   import kds_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic HOST_STROBE,
   input wire logic HOST_WRITE,
   input wire logic [2:0] PANEL_ADDRESS_BITS,
   input wire logic HOST_RVALID,
   input wire logic HOST_INT_N,
   input wire logic [2:0] HOST_INT_LEVEL,
   input wire logic [3:0] SCAN_CODE_A,
   input wire logic [3:0] SCAN_CODE_B,
   input wire logic BLANK_DIGITS_A_N,
   input wire logic BLANK_DIGITS_B_N,
   input wire logic [15:0] DIGIT_ANODE_A,
   input wire logic [13:0] DIGIT_ANODE_B,
   input wire logic [4:0] KEY_LED_ANODE,
   input wire logic [7:0] KEY_SELECT
);
   logic [2:0] live_q;
   logic [2:0] live_d;
   logic live;
   // The reset synchroniser holds outputs at their reset values a few cycles after release.
   always_comb begin
      live_d = (live_q == 3'h7) ? live_q : 3'(live_q + 3'h1);
   end
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) live_q <= 3'h0;
      else live_q <= live_d;
   end
   assign live = (live_q == 3'h7);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   // A scan step seen at the next edge means the select was dropped on the slot's last cycle.
   property p_anode_a;
      live && BLANK_DIGITS_A_N |=>
         DIGIT_ANODE_A == ($changed(SCAN_CODE_A) ? 16'h0 : 16'h1 << $past(SCAN_CODE_A));
   endproperty
   a_anode_a: assert property (p_anode_a) else $error("digit anode A wrong");
   property p_blank_a; live && !BLANK_DIGITS_A_N |=> DIGIT_ANODE_A == 16'h0; endproperty
   a_blank_a: assert property (p_blank_a) else $error("anode A driven while blanked");
   property p_anode_b;
      live |=> DIGIT_ANODE_B ==
         (($past(BLANK_DIGITS_B_N) && !$changed(SCAN_CODE_B)) ? 14'(16'h1 << $past(SCAN_CODE_B)) : 14'h0);
   endproperty
   a_anode_b: assert property (p_anode_b) else $error("digit anode B wrong");
   property p_led; live |-> KEY_LED_ANODE == DIGIT_ANODE_B[13:9]; endproperty
   a_led: assert property (p_led) else $error("key LED anode wrong");
   property p_keysel; live |=> KEY_SELECT == 8'h1 << $past(SCAN_CODE_B[2:0]); endproperty
   a_keysel: assert property (p_keysel) else $error("key select wrong");
   property p_scan;
      live && $changed(SCAN_CODE_A) |-> SCAN_CODE_A == 4'($past(SCAN_CODE_A) + 4'h1) && !BLANK_DIGITS_A_N;
   endproperty
   a_scan: assert property (p_scan) else $error("scan step wrong");
   property p_level; live |-> HOST_INT_LEVEL == (HOST_INT_N ? 3'h0 : HOST_INT_PRIORITY); endproperty
   a_level: assert property (p_level) else $error("interrupt level wrong");
   property p_release;
      live && HOST_STROBE && !HOST_WRITE && PANEL_ADDRESS_BITS == PANEL_SEL_B |=> HOST_RVALID && HOST_INT_N;
   endproperty
   a_release: assert property (p_release) else $error("read did not release interrupt");
   c_int: cover property ($fell(HOST_INT_N));
   c_read: cover property (HOST_RVALID);
   c_wrap: cover property (live && $fell(SCAN_CODE_A[3]));
endmodule : kds_chk

// file: verif/kds_keypad.sv
// Key matrix model: pressed crossings join a select line to a return line.
// Assumes one-hot active-high selects; released returns are pulled down.
`timescale 1ns/100ps
module kds_keypad (
   input wire logic [7:0] key_select,
   input wire logic [63:0] pressed,
   output logic [7:0] return_lines
);
   always_comb begin
      for (int l = 0; l < 8; l++) begin
         return_lines[l] = 1'b0;
         for (int r = 0; r < 8; r++) return_lines[l] |= key_select[r] & pressed[r * 8 + l];
      end
   end
endmodule : kds_keypad

// file: verif/tb_kds_top.sv
// Self-checking bench for the panel scanner with a key matrix model.
// Assumes the package timing constants; runs about a dozen display frames.
`timescale 1ns/100ps
module tb_kds_top
   import kds_pkg::*;
;
   logic clk = 0, rst_b = 0, stb = 0, wr = 0;
   logic [2:0] adr = 0;
   logic [3:0] dig = 0;
   logic [7:0] wd = 0, rl, rd, sel, cat, lo_a, hi_a;
   logic [63:0] pressed = 0;
   logic rv, int_n;
   logic [2:0] lvl;
   logic [3:0] sa, sb, al, ah, bl, bh;
   logic ba, bb;
   logic [15:0] an_a;
   logic [13:0] an_b;
   logic [4:0] led;
   int n_mismatch = 0, checks = 0;
   initial forever #2.5 clk = ~clk;
   kds_top dut_u (.CLK_SYS(clk), .RST_B(rst_b), .HOST_STROBE(stb), .HOST_WRITE(wr), .PANEL_ADDRESS_BITS(adr),
      .HOST_DIGIT(dig), .HOST_WDATA(wd), .KEY_RETURN_LINES(rl), .HOST_RDATA(rd), .HOST_RVALID(rv),
      .HOST_INT_N(int_n), .HOST_INT_LEVEL(lvl), .SCAN_CODE_A(sa), .SCAN_CODE_B(sb), .BLANK_DIGITS_A_N(ba),
      .BLANK_DIGITS_B_N(bb), .SEGMENT_BUS_A_LOW(al), .SEGMENT_BUS_A_HIGH(ah), .SEGMENT_BUS_B_LOW(bl),
      .SEGMENT_BUS_B_HIGH(bh), .DIGIT_ANODE_A(an_a), .DIGIT_ANODE_B(an_b), .KEY_LED_ANODE(led),
      .KEY_LED_CATHODE(cat), .KEY_SELECT(sel));
   kds_keypad pad_u (.key_select(sel), .pressed(pressed), .return_lines(rl));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic results();
      $display("mismatches %0d, checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results
   localparam int FRAME = DIGIT_CYCLES * NUM_DIGITS;
   task automatic access(input logic w, input logic [2:0] a, input logic [3:0] d, input logic [7:0] v);
      @(negedge clk);
      stb = 1;
      wr = w;
      adr = a;
      dig = d;
      wd = v;
      @(negedge clk);
      stb = 0;
      if (!w) chk({7'h0, rv}, 8'h1);
   endtask : access
   task automatic wait_digit(input logic b, input logic [3:0] d);
      int n;
      for (n = 0; n < 2 * FRAME && !((b ? sb : sa) == d && (b ? bb : ba) && (b ? |an_b : |an_a)); n++)
         @(negedge clk);
      if (n == 2 * FRAME) chk(8'h1, 8'h0);
   endtask : wait_digit
   task automatic t_segments();
      access(1, PANEL_SEL_A, 4'h5, 8'ha5);
      access(1, 3'h2, 4'h5, 8'hff);
      access(1, PANEL_SEL_B, 4'h3, 8'h3c);
      access(1, PANEL_SEL_B, 4'ha, 8'h96);
      wait_digit(0, 4'h5);
      chk({ah, al}, 8'ha5);
      chk({7'h0, an_a == 16'h0020}, 8'h1);
      wait_digit(1, 4'h3);
      chk({bh, bl}, 8'h3c);
      wait_digit(1, 4'ha);
      chk({3'h0, led}, 8'h02);
      chk(cat, 8'h96);
   endtask : t_segments
   task automatic t_key();
      int n;
      pressed = 64'h1 << 21 | 64'h1 << 57;
      for (n = 0; n < (DEBOUNCE_FRAMES + 2) * FRAME && int_n !== 1'b0; n++) @(negedge clk);
      chk({7'h0, int_n}, 8'h0);
      chk({5'h0, lvl}, {5'h0, HOST_INT_PRIORITY});
      access(0, PANEL_SEL_A, 4'h0, 8'h0);
      chk(rd, 8'h0);
      chk({7'h0, int_n}, 8'h0);
      access(0, PANEL_SEL_B, 4'h0, 8'h0);
      chk(rd, 8'h95);
      chk({7'h0, int_n}, 8'h1);
      pressed = 0;
   endtask : t_key
   // Two keys on one select line must never report; once one is let go the other reports alone.
   task automatic t_lockout();
      int n;
      pressed = 64'h1 << 8 | 64'h1 << 9;
      for (n = 0; n < (DEBOUNCE_FRAMES + 1) * FRAME && int_n === 1'b1; n++) @(negedge clk);
      chk({7'h0, int_n}, 8'h1);
      pressed = 64'h1 << 9;
      for (n = 0; n < (DEBOUNCE_FRAMES + 2) * FRAME && int_n !== 1'b0; n++) @(negedge clk);
      chk({7'h0, int_n}, 8'h0);
      access(0, PANEL_SEL_B, 4'h0, 8'h0);
      chk(rd, 8'h89);
      pressed = 0;
   endtask : t_lockout
   initial begin
      repeat (2) @(negedge clk);
      chk({7'h0, int_n}, 8'h1);
      chk({4'h0, |an_a, |an_b, ba, bb}, 8'h0);
      rst_b = 1;
      repeat (4) @(negedge clk);
      t_segments();
      t_key();
      t_lockout();
      results();
   end
   initial begin
      repeat (17 * FRAME) @(posedge clk);
      n_mismatch++;
      results();
   end
endmodule : tb_kds_top
bind kds_top kds_chk chk_u (
   .CLK_SYS(CLK_SYS),
   .RST_B(RST_B),
   .HOST_STROBE(HOST_STROBE),
   .HOST_WRITE(HOST_WRITE),
   .PANEL_ADDRESS_BITS(PANEL_ADDRESS_BITS),
   .HOST_RVALID(HOST_RVALID),
   .HOST_INT_N(HOST_INT_N),
   .HOST_INT_LEVEL(HOST_INT_LEVEL),
   .SCAN_CODE_A(SCAN_CODE_A),
   .SCAN_CODE_B(SCAN_CODE_B),
   .BLANK_DIGITS_A_N(BLANK_DIGITS_A_N),
   .BLANK_DIGITS_B_N(BLANK_DIGITS_B_N),
   .DIGIT_ANODE_A(DIGIT_ANODE_A),
   .DIGIT_ANODE_B(DIGIT_ANODE_B),
   .KEY_LED_ANODE(KEY_LED_ANODE),
   .KEY_SELECT(KEY_SELECT)
);
